/* File: test/ssc_host_model.sv */
// host-side two-wire bus controller model for the status unit
`timescale 1ns/1ps
`default_nettype none
module ssc_host_model (
	// clock and resolved data line
	input wire logic clk_i,
	input wire logic sda_i,
	// open-drain pins, sda_low_o pulls the data line low
	output logic scl_o,
	output logic sda_low_o,
	// each byte read back from the device
	output logic rd_valid_o,
	output logic [7:0] rd_byte_o
);
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
		rd_valid_o = 1'b0;
		rd_byte_o = 8'h00;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// one 25-cycle bus clock; data set well before the rise, sampled at the end of the high phase
	task automatic bit_x(input logic b, output logic s);
		sda_low_o <= ~b;
		wt(6);
		scl_o <= 1'b1;
		wt(12);
		s = sda_i;
		scl_o <= 1'b0;
		wt(7);
	endtask

	// scl stands high between frames, so start and stop are the only edges then
	task automatic frame_start;
		sda_low_o <= 1'b1;
		wt(12);
		scl_o <= 1'b0;
		wt(7);
	endtask

	task automatic frame_stop;
		sda_low_o <= 1'b1;
		wt(6);
		scl_o <= 1'b1;
		wt(12);
		sda_low_o <= 1'b0;
		wt(12);
	endtask

	// byte msb first, then the ninth clock with the line released for the ack
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_x(d[i], s);
		bit_x(1'b1, ack);
	endtask

	// write of n bytes taken from the low end of d, most significant first
	task automatic write(input logic [6:0] a, input logic [39:0] d, input int n,
		output logic ack0);
		logic s;
		frame_start();
		wr_byte({a, 1'b0}, ack0);
		for (int i = n - 1; i >= 0; i--) wr_byte(d[8*i +: 8], s);
		frame_stop();
	endtask

	// read of n bytes, ack on all but the last, which is refused to end it
	task automatic read(input logic [6:0] a, input int n);
		logic s;
		logic [7:0] v;
		frame_start();
		wr_byte({a, 1'b1}, s);
		for (int k = 0; k < n; k++) begin
			for (int i = 7; i >= 0; i--) begin
				bit_x(1'b1, s);
				v[i] = s;
			end
			rd_byte_o <= v;
			rd_valid_o <= 1'b1;
			@(posedge clk_i);
			rd_valid_o <= 1'b0;
			bit_x(k == n - 1, s);
		end
		frame_stop();
	endtask
endmodule
`default_nettype wire

/* File: test/tb_ssc_status_unit.sv */
// self-checking bench for the status unit, host model on the bus
`timescale 1ns/1ps
`default_nettype none
`define SSC_CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
$display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb_ssc_status_unit;
	import ssc_pkg::*;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic rh_alert_i = 1'b0;
	logic t_alert_i = 1'b0;
	logic soft_reset_i = 1'b0;
	wire logic scl;
	wire logic sda_low;
	wire logic sda_line;
	wire logic sda_o;
	wire logic sda_oe_n_o;
	wire logic [15:0] status_o;
	wire logic heater_on_o;
	wire logic rd_valid;
	wire logic [7:0] rd_byte;
	int miscompares = 0;
	int total_checks = 0;
	int seed = 32690;
	logic [7:0] exp_q[$];
	logic [7:0] e;
	logic [15:0] exp_st;
	logic [15:0] w;
	logic [7:0] c;
	logic ack;

	always #2.5 clk_i = ~clk_i;
	// pulled-up data line, low when either party pulls it
	assign sda_line = sda_low ? 1'b0 : (!sda_oe_n_o ? sda_o : 1'b1);

	ssc_status_unit i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda_line),
		.sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .rh_alert_i(rh_alert_i),
		.t_alert_i(t_alert_i), .soft_reset_i(soft_reset_i), .status_o(status_o),
		.heater_on_o(heater_on_o));
	ssc_host_model i_host (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl),
		.sda_low_o(sda_low), .rd_valid_o(rd_valid), .rd_byte_o(rd_byte));

	// bench's own crc, bitwise msb first, independent of the design's
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] r;
		r = 8'hff;
		for (int i = 15; i >= 0; i--) r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? 8'h31 : 8'h00);
		return r;
	endfunction

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic settle;
		repeat (10) @(posedge clk_i);
		`SSC_CHK(status_o, exp_st)
		`SSC_CHK(heater_on_o, exp_st[13])
	endtask

	task automatic send(input logic [39:0] d, input int n);
		i_host.write(DEV_ADDR, d, n, ack);
		`SSC_CHK(ack, 1'b0)
		settle();
	endtask

	// latch a snapshot, then read word and crc back through the bus
	task automatic rd_status;
		// a known command executes, so the command status bit drops
		exp_st[1] = 1'b0;
		send({24'h0, CMD_READ_STATUS}, 2);
		exp_q.push_back(exp_st[15:8]);
		exp_q.push_back(exp_st[7:0]);
		exp_q.push_back(crc8(exp_st));
		i_host.read(DEV_ADDR, 3);
		`SSC_CHK(exp_q.size(), 0)
	endtask

	task automatic pulse(input int k);
		@(posedge clk_i);
		if (k == 0) rh_alert_i <= 1'b1;
		else if (k == 1) t_alert_i <= 1'b1;
		else soft_reset_i <= 1'b1;
		@(posedge clk_i);
		{rh_alert_i, t_alert_i, soft_reset_i} <= 3'h0;
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------
	// result watcher: oldest note against each byte read
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rd_valid === 1'b1) begin
			`SSC_CHK(exp_q.size() > 0, 1'b1)
			e = exp_q.size() > 0 ? exp_q.pop_front() : 8'h00;
			`SSC_CHK(rd_byte, e)
		end
	end

	// a hung bus transfer would otherwise never end the run
	initial begin
		#400000;
		miscompares++;
		close_out();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		exp_st = STATUS_RST;
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'b1;
		settle();
		`SSC_CHK(crc8(CRC_CHECK_WORD), CRC_CHECK_VALUE)
		rd_status();
		// another address is refused and changes nothing
		i_host.write(DEV_ADDR ^ 7'h01, {24'h0, CMD_CLEAR}, 2, ack);
		`SSC_CHK(ack, 1'b1)
		settle();
		exp_st[13] = 1'b1;
		send({24'h0, CMD_HEATER_ON}, 2);
		exp_st = exp_st & ~STICKY_MASK;
		send({24'h0, CMD_CLEAR}, 2);
		pulse(0);
		exp_st[11] = 1'b1;
		exp_st[15] = 1'b1;
		settle();
		pulse(1);
		exp_st[10] = 1'b1;
		rd_status();
		exp_st = exp_st & ~STICKY_MASK;
		send({24'h0, CMD_CLEAR}, 2);
		exp_st[1] = 1'b1;
		send({24'h0, 16'h1234}, 2);
		send({16'h0, CMD_HEATER_ON, 8'h00}, 3);
		// data writes with random words, crc alternately good and corrupted
		for (int i = 0; i < 6; i++) begin
			w = 16'($random(seed));
			c = crc8(w);
			if (i[0]) c = c ^ (8'h01 << (i % 8));
			exp_st[0] = i[0];
			exp_st[1] = i[0];
			send({CMD_HEATER_ON, w, c}, 5);
		end
		// the published check word must pass the device's write check
		exp_st[1:0] = 2'h0;
		send({CMD_HEATER_ON, CRC_CHECK_WORD, CRC_CHECK_VALUE}, 5);
		rd_status();
		pulse(2);
		exp_st[4] = 1'b1;
		exp_st[13] = 1'b0;
		settle();
		exp_st[13] = 1'b1;
		send({24'h0, CMD_HEATER_ON}, 2);
		exp_st[13] = 1'b0;
		send({24'h0, CMD_HEATER_OFF}, 2);
		// hard reset in mid-run restores the reset word
		@(posedge clk_i);
		rstn_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rstn_i <= 1'b1;
		// give the pin synchroniser time to settle before the next start
		repeat (4) @(posedge clk_i);
		exp_st = STATUS_RST;
		rd_status();
		close_out();
	end
endmodule
`default_nettype wire

/* File: verilog/ssc_crc8.sv */
// crc-8 over one two-byte data word
`timescale 1ns/1ps
`default_nettype none
module ssc_crc8
	import ssc_pkg::*;
(
	// data word and its checksum
	input wire logic [15:0] word_i,
	output logic [7:0] crc_o
);

	// ----------------------------------------
	// bitwise crc, msb first, unreflected
	// ----------------------------------------
	function automatic logic [7:0] crc8_word(input logic [15:0] d);
		logic [7:0] c;
		logic fb;
		c = CRC_INIT; // RULE_10
		for (int i = 15; i >= 0; i--) begin
			fb = c[7] ^ d[i];
			c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00); // RULE_10
		end
		return c ^ CRC_XOROUT; // RULE_10
	endfunction

	// restarts from the init value for every word
	assign crc_o = crc8_word(word_i); // RULE_09

endmodule
`default_nettype wire

/* File: verilog/ssc_pin_sync.sv */
// three-flop synchroniser with agreement filter for bus pins
`timescale 1ns/1ps
`default_nettype none
module ssc_pin_sync
	import ssc_pkg::*;
#(
	parameter int W = 2
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// pins and filtered levels
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] level_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] filt;
	} ssc_sync_s;

	ssc_sync_s q;
	ssc_sync_s n;

	// a bit only changes once stages two and three agree
	always_comb begin
		n = q;
		n.s1 = pin_i;
		n.s2 = q.s1;
		n.s3 = q.s2;
		for (int i = 0; i < W; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				n.filt[i] = q.s2[i];
			end
		end
	end

	// idle bus lines are high, so reset to ones
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '{default: '1};
		end else begin
			q <= n;
		end
	end

	assign level_o = q.filt;

	chk_sync_follow: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(q.s2 == q.s3) |=> (q.filt == $past(q.s2)))
		else $error("filtered level did not follow agreeing stages");

endmodule
`default_nettype wire

/* File: verilog/ssc_pkg.sv */
// constants and types shared by the sensor status and crc unit
package ssc_pkg;

	// ----------------------------------------
	// status word layout
	// ----------------------------------------
	localparam int STAT_W = 16;
	localparam int BIT_ALERT = 15;
	localparam int BIT_HEATER = 13;
	localparam int BIT_RH = 11;
	localparam int BIT_T = 10;
	localparam int BIT_RESET = 4;
	localparam int BIT_CMD = 1;
	localparam int BIT_WCRC = 0;
	localparam logic [15:0] STATUS_RST = 16'h8010;
	localparam logic [15:0] STICKY_MASK = 16'h8c10;
	localparam logic [15:0] DEFINED_MASK = 16'hac13;

	// ----------------------------------------
	// crc-8 properties
	// ----------------------------------------
	localparam logic [7:0] CRC_POLY = 8'h31;
	localparam logic [7:0] CRC_INIT = 8'hff;
	localparam logic [7:0] CRC_XOROUT = 8'h00;
	localparam logic [15:0] CRC_CHECK_WORD = 16'hbeef;
	localparam logic [7:0] CRC_CHECK_VALUE = 8'h92;

	// ----------------------------------------
	// commands and bus framing
	// ----------------------------------------
	localparam logic [15:0] CMD_CLEAR = 16'h3041;
	localparam logic [15:0] CMD_HEATER_ON = 16'h306d;
	localparam logic [15:0] CMD_HEATER_OFF = 16'h3066;
	localparam logic [15:0] CMD_READ_STATUS = 16'hf300;
	localparam logic [6:0] DEV_ADDR = 7'h40;
	localparam logic [2:0] WR_CMD_BYTES = 3'h2;
	localparam logic [2:0] WR_DATA_BYTES = 3'h5;
	localparam logic [1:0] RD_LAST_IDX = 2'h2;

	// bus states, gray coded along the usual path
	typedef enum logic [2:0] {
		BUS_IDLE = 3'h0,
		BUS_ADDR = 3'h1,
		BUS_ADDR_ACK = 3'h3,
		BUS_WR_BYTE = 3'h2,
		BUS_WR_ACK = 3'h6,
		BUS_RD_BYTE = 3'h7,
		BUS_RD_ACK = 3'h5
	} ssc_bus_e;

endpackage

/* File: verilog/ssc_status_unit.sv */
// status word, command decode and crc checking behind the two-wire bus
// ----------------------------------------
// Behaviour
// RULE_01: bit 15 shows pending alert, resets one
// RULE_02: bit 13 shows heater on or off
// RULE_03: bits 11 and 10 flag humidity/temperature alerts
// RULE_04: bit 4 set by any reset
// RULE_05: bit 1 set when command not processed
// RULE_06: bit 0 set on bad write checksum
// RULE_07: clear command zeroes bits 15,11,10,4
// RULE_08: every data word followed by crc byte
// RULE_09: crc over only the two preceding bytes
// RULE_10: crc polynomial 0x31, init 0xff, unreflected
// RULE_11: crc protects reads and checked writes
// RULE_12: heater disabled after any reset
// RULE_13: reserved status bits read as zero
// RULE_14: status read returns msb, lsb, crc
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
module ssc_status_unit
	import ssc_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// two-wire bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	// sensor events, one-cycle pulses
	input wire logic rh_alert_i,
	input wire logic t_alert_i,
	input wire logic soft_reset_i,
	// state seen by the rest of the sensor
	output logic [15:0] status_o,
	output logic heater_on_o
);

	typedef struct packed {
		ssc_bus_e st;
		logic [2:0] bitcnt;
		logic byte_done;
		logic [7:0] shreg;
		logic rw;
		logic nack;
		logic [2:0] wr_idx;
		logic [1:0] rd_idx;
		logic [15:0] cmd;
		logic [15:0] wdata;
		logic [7:0] wcrc;
		logic [15:0] status;
		logic [15:0] tx_word;
		logic [7:0] tx_byte;
		logic sda_oe_n;
		logic sda_low;
		logic scl_q;
		logic sda_q;
	} ssc_state_s;

	ssc_state_s q;
	ssc_state_s n;
	logic [1:0] pins_f;
	logic scl_f;
	logic sda_f;
	logic [7:0] tx_crc;
	logic [7:0] rx_crc;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic exec_now;
	logic cmd_ok;
	logic wr_bad;
	logic [7:0] nb;

	// ----------------------------------------
	// pin sampling and crc units
	// ----------------------------------------
	ssc_pin_sync #(.W(2)) u_sync (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.pin_i({scl_i, sda_i}),
		.level_o(pins_f)
	);

	// outgoing word crc, recomputed from the snapshot only
	ssc_crc8 u_tx_crc (
		.word_i(q.tx_word),
		.crc_o(tx_crc)
	);

	// incoming write word crc
	ssc_crc8 u_rx_crc (
		.word_i(q.wdata),
		.crc_o(rx_crc)
	);

	assign scl_f = pins_f[1];
	assign sda_f = pins_f[0];

	// bus conditions from filtered levels
	assign scl_rise = scl_f & ~q.scl_q;
	assign scl_fall = ~scl_f & q.scl_q;
	assign start_c = q.scl_q & scl_f & q.sda_q & ~sda_f;
	assign stop_c = q.scl_q & scl_f & ~q.sda_q & sda_f;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// byte order of a status readout: msb, lsb, then crc
	function automatic logic [7:0] pick_byte(input logic [1:0] idx, input logic [15:0] w,
		input logic [7:0] c);
		case (idx)
			2'h0: pick_byte = w[15:8];
			2'h1: pick_byte = w[7:0];
			default: pick_byte = c;
		endcase
	endfunction

	function automatic logic known_cmd(input logic [15:0] c);
		known_cmd = (c == CMD_CLEAR) || (c == CMD_HEATER_ON) ||
			(c == CMD_HEATER_OFF) || (c == CMD_READ_STATUS);
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		n = q;
		exec_now = 1'b0;
		cmd_ok = 1'b0;
		wr_bad = 1'b0;
		nb = 8'h00;
		n.scl_q = scl_f;
		n.sda_q = sda_f;
		if (start_c) begin
			// repeated start also lands here and restarts framing
			n.st = BUS_ADDR;
			n.bitcnt = 3'h0;
			n.byte_done = 1'b0;
			n.wr_idx = 3'h0;
			n.sda_oe_n = 1'b1;
		end else if (stop_c) begin
			exec_now = (q.rw == 1'b0) && (q.wr_idx != 3'h0);
			n.st = BUS_IDLE;
			n.sda_oe_n = 1'b1;
		end else begin
			if (scl_rise) begin
				case (q.st)
					BUS_ADDR, BUS_WR_BYTE: begin
						n.shreg = {q.shreg[6:0], sda_f};
						n.bitcnt = q.bitcnt + 3'h1;
						n.byte_done = (q.bitcnt == 3'h7);
					end
					BUS_RD_ACK: n.nack = sda_f;
					default: ;
				endcase
			end
			if (scl_fall) begin
				case (q.st)
					BUS_ADDR: begin
						if (q.byte_done) begin
							n.byte_done = 1'b0;
							if (q.shreg[7:1] == DEV_ADDR) begin
								n.rw = q.shreg[0];
								n.st = BUS_ADDR_ACK;
								n.sda_oe_n = 1'b0;
							end else begin
								n.st = BUS_IDLE;
							end
						end
					end
					BUS_ADDR_ACK: begin
						n.bitcnt = 3'h0;
						if (q.rw) begin
							nb = pick_byte(2'h0, q.tx_word, tx_crc); // RULE_14
							n.rd_idx = 2'h0;
							n.tx_byte = nb;
							n.sda_oe_n = nb[7];
							n.st = BUS_RD_BYTE;
						end else begin
							n.sda_oe_n = 1'b1;
							n.st = BUS_WR_BYTE;
						end
					end
					BUS_WR_BYTE: begin
						if (q.byte_done) begin
							n.byte_done = 1'b0;
							case (q.wr_idx)
								3'h0: n.cmd[15:8] = q.shreg;
								3'h1: n.cmd[7:0] = q.shreg;
								3'h2: n.wdata[15:8] = q.shreg; // RULE_09
								3'h3: n.wdata[7:0] = q.shreg; // RULE_09
								3'h4: n.wcrc = q.shreg; // RULE_08
								default: ;
							endcase
							if (q.wr_idx != 3'h7) begin
								n.wr_idx = q.wr_idx + 3'h1;
							end
							n.sda_oe_n = 1'b0;
							n.st = BUS_WR_ACK;
						end
					end
					BUS_WR_ACK: begin
						n.sda_oe_n = 1'b1;
						n.bitcnt = 3'h0;
						n.st = BUS_WR_BYTE;
					end
					BUS_RD_BYTE: begin
						if (q.bitcnt == 3'h7) begin
							n.sda_oe_n = 1'b1;
							n.st = BUS_RD_ACK;
						end else begin
							n.bitcnt = q.bitcnt + 3'h1;
							n.tx_byte = {q.tx_byte[6:0], 1'b0};
							n.sda_oe_n = q.tx_byte[6];
						end
					end
					BUS_RD_ACK: begin
						if (!q.nack && (q.rd_idx != RD_LAST_IDX)) begin
							nb = pick_byte(q.rd_idx + 2'h1, q.tx_word, tx_crc); // RULE_08
							n.rd_idx = q.rd_idx + 2'h1;
							n.tx_byte = nb;
							n.sda_oe_n = nb[7];
							n.bitcnt = 3'h0;
							n.st = BUS_RD_BYTE;
						end else begin
							n.sda_oe_n = 1'b1;
							n.st = BUS_IDLE;
						end
					end
					default: n.st = BUS_IDLE;
				endcase
			end
		end

		// command execution at the end of a write transfer
		if (exec_now) begin
			if (q.wr_idx == WR_DATA_BYTES) begin
				wr_bad = (rx_crc != q.wcrc); // RULE_11
				n.status[BIT_WCRC] = wr_bad; // RULE_06
				cmd_ok = ~wr_bad;
			end else if (q.wr_idx == WR_CMD_BYTES) begin
				cmd_ok = known_cmd(q.cmd);
			end
			n.status[BIT_CMD] = ~cmd_ok; // RULE_05
			if (cmd_ok && (q.wr_idx == WR_CMD_BYTES)) begin
				case (q.cmd)
					CMD_CLEAR: n.status = q.status & ~STICKY_MASK; // RULE_07
					CMD_HEATER_ON: n.status[BIT_HEATER] = 1'b1; // RULE_02
					CMD_HEATER_OFF: n.status[BIT_HEATER] = 1'b0; // RULE_02
					CMD_READ_STATUS: n.tx_word = q.status; // RULE_14
					default: ;
				endcase
			end
		end

		// events come last so a set wins over a same-cycle clear
		if (rh_alert_i) begin
			n.status[BIT_RH] = 1'b1; // RULE_03
			n.status[BIT_ALERT] = 1'b1; // RULE_01
		end
		if (t_alert_i) begin
			n.status[BIT_T] = 1'b1; // RULE_03
			n.status[BIT_ALERT] = 1'b1; // RULE_01
		end
		if (soft_reset_i) begin
			n.status[BIT_RESET] = 1'b1; // RULE_04
			n.status[BIT_HEATER] = 1'b0; // RULE_12
		end
		n.status = n.status & DEFINED_MASK; // RULE_13
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	// hard reset and supply loss both arrive as rstn_i
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '{st: BUS_IDLE, status: STATUS_RST, sda_oe_n: 1'b1, scl_q: 1'b1,
				sda_q: 1'b1, default: '0}; // RULE_04 RULE_12
		end else begin
			q <= n;
		end
	end

	// open drain: the line is only ever pulled low
	assign sda_o = q.sda_low;
	assign sda_oe_n_o = q.sda_oe_n;
	assign status_o = q.status;
	assign heater_on_o = q.status[BIT_HEATER];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_alert_rh_set: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE_01 RULE_03
		rh_alert_i |=> (q.status[BIT_RH] && q.status[BIT_ALERT]))
		else $error("humidity alert did not set its flags");

	chk_alert_t_set: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE_03
		t_alert_i |=> (q.status[BIT_T] && q.status[BIT_ALERT]))
		else $error("temperature alert did not set its flags");

	chk_heater_cmd: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE_02
		(exec_now && cmd_ok && q.wr_idx == WR_CMD_BYTES && q.cmd == CMD_HEATER_ON
		&& !soft_reset_i) |=> heater_on_o ##1 (heater_on_o == q.status[BIT_HEATER]))
		else $error("heater on command not reflected");

	chk_soft_reset: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE_04 RULE_12
		soft_reset_i |=> (q.status[BIT_RESET] && !q.status[BIT_HEATER]))
		else $error("soft reset did not set reset flag and stop heater");

	chk_clear_flags: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE_07
		(exec_now && cmd_ok && q.wr_idx == WR_CMD_BYTES && q.cmd == CMD_CLEAR
		&& !rh_alert_i && !t_alert_i && !soft_reset_i)
		|=> ((q.status & STICKY_MASK) == 16'h0000) && ($past(q.status[BIT_HEATER])
		== q.status[BIT_HEATER]))
		else $error("clear command left a sticky flag set");

	chk_cmd_status: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE_05
		exec_now |=> (q.status[BIT_CMD] == !$past(cmd_ok)))
		else $error("command status bit wrong after execution");

	chk_write_crc: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE_06 RULE_11
		(exec_now && q.wr_idx == WR_DATA_BYTES)
		|=> (q.status[BIT_WCRC] == ($past(rx_crc) != $past(q.wcrc))))
		else $error("write checksum status wrong");

	chk_reserved_zero: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE_13
		(q.status & ~DEFINED_MASK) == 16'h0000)
		else $error("reserved status bit is set");

	chk_crc_vector: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE_10
		(q.wdata == CRC_CHECK_WORD) |-> (rx_crc == CRC_CHECK_VALUE))
		else $error("crc of check word is wrong");

	chk_read_first: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE_14
		(q.st == BUS_ADDR_ACK && q.rw && scl_fall && !start_c && !stop_c)
		|=> (q.st == BUS_RD_BYTE) && (q.tx_byte == q.tx_word[15:8])
		&& (q.sda_oe_n == q.tx_word[15]))
		else $error("status readout did not start with its msb");

	chk_read_crc: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE_08
		(q.st == BUS_RD_ACK && scl_fall && !q.nack && q.rd_idx == 2'h1
		&& !start_c && !stop_c) |=> (q.tx_byte == tx_crc) && (q.rd_idx == RD_LAST_IDX))
		else $error("third read byte is not the crc");

	chk_idle_release: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(q.st == BUS_IDLE) |-> q.sda_oe_n)
		else $error("data line held while idle");

endmodule
`default_nettype wire
